// >>> pkg/typec_vendor_pkg.sv
package typec_vendor_pkg;
  // ---------------------------------------------------------------
  // register offsets and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_ALARM_LOW_UPPER = 8'h79;
  localparam logic [7:0] ADDR_EVENT_FLAGS     = 8'h90;
  localparam logic [7:0] ADDR_EVENT_EN        = 8'h92;
  localparam logic [7:0] ADDR_GEN_CTRL        = 8'h94;
  localparam logic [7:0] ADDR_TX_CTRL         = 8'h95;
  localparam logic [7:0] RST_ZERO             = 8'h00;
  localparam logic [7:0] RST_GEN_CTRL         = 8'h04;
  // ---------------------------------------------------------------
  // field positions and masks
  // ---------------------------------------------------------------
  localparam int         FLAG_TIMER_BIT  = 4;
  localparam int         FLAG_CC_BIT     = 3;
  localparam int         FLAG_OT_BIT     = 2;
  localparam logic [7:0] FLAG_MASK       = 8'h1C;
  localparam logic [7:0] EN_WMASK        = 8'h1F;
  localparam logic [7:0] THR_UPPER_MASK  = 8'h03;
  localparam logic [7:0] TX_WMASK        = 8'h04;
  localparam logic [7:0] GEN_PD_MASK     = 8'h40;
  localparam int         GEN_POLICY      = 7;
  localparam int         GEN_PD_RST      = 6;
  localparam int         GEN_GLOBAL      = 5;
  localparam int         GEN_SAMPLE_CTL  = 4;
  localparam int         GEN_RATE_LSB    = 2;
  localparam int         TX_BIST_CONT    = 2;
  localparam int         TX_FRS          = 1;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ         = 40_000;
  localparam int TICK_MS         = 1;
  localparam int TICK_CYCLES     = TICK_MS * CLK_KHZ;
  localparam int SAMPLE_MS_00    = 1;
  localparam int SAMPLE_MS_01    = 2;
  localparam int SAMPLE_MS_10    = 8;
  localparam int SAMPLE_MS_11    = 16;
  localparam int DUTY_PCT_00     = 30;
  localparam int DUTY_PCT_01     = 10;
  localparam int DUTY_PCT_10     = 50;
  localparam int DUTY_PCT_11     = 60;
  localparam int PCT_FULL        = 100;
  localparam int DRP_PERIOD_MS   = 50;
  localparam int BIST_CONT_MS    = 50;
  localparam int BIST_CONT_CYC   = BIST_CONT_MS * CLK_KHZ;
  localparam int PD_RESET_CYCLES = 16;
  localparam logic [3:0] I2C_BITS = 4'h8;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    I2C_IDLE      = 3'h0,
    I2C_ADDR      = 3'h1,
    I2C_ADDR_ACK  = 3'h3,
    I2C_WRITE     = 3'h2,
    I2C_WRITE_ACK = 3'h6,
    I2C_READ      = 3'h7,
    I2C_READ_ACK  = 3'h5
  } i2c_state_e;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_access_s;
endpackage

// >>> logic/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import typec_vendor_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;

  // a bit moves only once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ff1  <= '0;
      ff2  <= '0;
      ff3  <= '0;
      dout <= '0;
    end else begin
      ff1 <= din;
      ff2 <= ff1;
      ff3 <= ff2;
      for (int i = 0; i < W; i++) begin
        if (ff2[i] == ff3[i]) begin
          dout[i] <= ff3[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> logic/interval_timer.sv
`timescale 1ns/1ps
`default_nettype none
module interval_timer
  import typec_vendor_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         adv,
  input  wire logic [W-1:0] period,
  output logic      [W-1:0] count,
  output logic              done
);
  // done is a one-cycle pulse on the step that closes a period
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count <= '0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (adv) begin
        if (count >= period - W'(1)) begin
          count <= '0;
          done  <= 1'b1;
        end else begin
          count <= count + W'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> logic/typec_port_vendor_ctrl_regs.sv
`timescale 1ns/1ps
`default_nettype none
module typec_port_vendor_ctrl_regs
  import typec_vendor_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR         = 7'h20,
  parameter int         TICK_CYC         = TICK_CYCLES,
  parameter int         BIST_CONT_CYCLES = BIST_CONT_CYC,
  parameter int         DRP_MS           = DRP_PERIOD_MS
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [9:0] vbus_level,
  input  wire logic [7:0] vbus_low_alarm_lower,
  input  wire logic       voltage_alarm_inhibit,
  input  wire logic       slow_timer_expire,
  input  wire logic       cc_over_limit,
  input  wire logic       port_attached,
  input  wire logic       thermal_shutdown_detector,
  input  wire logic       auto_toggle_enable,
  input  wire logic       bist_mode2_start,
  input  wire logic       fast_swap_sent,
  output logic            vbus_undervoltage_flag,
  output logic            vendor_irq,
  output logic            read_clear_policy,
  output logic            pd_engine_soft_reset,
  output logic            whole_chip_soft_reset,
  output logic            cc_sample_strobe,
  output logic            advertise_dfp,
  output logic            bist_carrier_on,
  output logic            fast_swap_tx
);
  localparam int BW = $clog2(BIST_CONT_CYCLES + 1);

  logic [7:0]  vendor_event_flags;
  logic [7:0]  vendor_event_enables;
  logic [7:0]  port_general_control;
  logic [7:0]  biphase_transmit_control;
  logic [7:0]  vbus_low_alarm_upper;
  logic [9:0]  vbus_low_alarm_level;
  logic        soft_rst;
  logic [3:0]  pins_raw;
  logic [3:0]  pins;
  logic        scl_s;
  logic        sda_s;
  logic        scl_q;
  logic        sda_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  i2c_state_e  state;
  logic [3:0]  bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  ptr;
  logic        ptr_loaded;
  logic        is_read;
  logic [7:0]  rd_byte;
  reg_access_s acc;
  logic [7:0]  ev_set;
  logic [7:0]  ev_clr;
  logic [7:0]  next_gen;
  logic [4:0]  pd_cnt;
  logic        pd_done;
  logic        ms_tick;
  logic        sample_due;
  logic [7:0]  drp_cnt;
  logic        toggling;
  logic        toggle_due;
  logic [BW-1:0] bist_cnt;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic wr_hit(input reg_access_s a, input logic [7:0] off);
    return a.wr && (a.addr == off);
  endfunction

  function automatic logic [4:0] sample_ms(input logic [1:0] rate);
    case (rate)
      2'h0:    return 5'(SAMPLE_MS_00);
      2'h1:    return 5'(SAMPLE_MS_01);
      2'h2:    return 5'(SAMPLE_MS_10);
      default: return 5'(SAMPLE_MS_11);
    endcase
  endfunction

  function automatic logic [7:0] dfp_ms(input logic [1:0] duty);
    int pct;
    case (duty)
      2'h0:    pct = DUTY_PCT_00;
      2'h1:    pct = DUTY_PCT_01;
      2'h2:    pct = DUTY_PCT_10;
      default: pct = DUTY_PCT_11;
    endcase
    return 8'((DRP_MS * pct) / PCT_FULL);
  endfunction

  function automatic logic [7:0] read_mux(input logic [7:0] a);
    case (a)
      ADDR_ALARM_LOW_UPPER: return vbus_low_alarm_upper;
      ADDR_EVENT_FLAGS:     return vendor_event_flags;
      ADDR_EVENT_EN:        return vendor_event_enables;
      ADDR_GEN_CTRL:        return port_general_control;
      ADDR_TX_CTRL:         return biphase_transmit_control;
      default:              return RST_ZERO;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // I2C slave
  // ---------------------------------------------------------------
  // bus lines idle high; carried inverted so the sync's zero reset reads as idle
  assign pins_raw  = {thermal_shutdown_detector, cc_over_limit, ~sda_in, ~scl};
  assign scl_s     = ~pins[0];
  assign sda_s     = ~pins[1];
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
  assign bus_stop  = scl_s & scl_q & ~sda_q & sda_s;
  // process form so a register change behind an unchanged ptr is seen
  always_comb rd_byte = read_mux(ptr);
  assign sda_out   = 1'b0;

  pin_sync #(.W(4)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .din     (pins_raw),
    .dout    (pins)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // the engine ignores the soft reset so the write that fires it still acks
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state      <= I2C_IDLE;
      bit_cnt    <= '0;
      shreg      <= '0;
      ptr        <= '0;
      ptr_loaded <= 1'b0;
      is_read    <= 1'b0;
      sda_oe     <= 1'b0;
      acc        <= '0;
    end else begin
      acc.wr <= 1'b0;
      acc.rd <= 1'b0;
      if (bus_start) begin
        state      <= I2C_ADDR;
        bit_cnt    <= '0;
        sda_oe     <= 1'b0;
        ptr_loaded <= 1'b0;
      end else if (bus_stop) begin
        state  <= I2C_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          I2C_ADDR, I2C_WRITE: begin
            shreg   <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          I2C_READ: begin
            shreg   <= {shreg[6:0], 1'b0};
            bit_cnt <= bit_cnt + 4'h1;
          end
          I2C_READ_ACK: begin
            if (sda_s) begin
              state <= I2C_IDLE;
            end
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          I2C_ADDR: begin
            if (bit_cnt == I2C_BITS) begin
              if (shreg[7:1] == DEV_ADDR) begin
                state   <= I2C_ADDR_ACK;
                sda_oe  <= 1'b1;
                is_read <= shreg[0];
              end else begin
                state <= I2C_IDLE;
              end
            end
          end
          I2C_ADDR_ACK, I2C_READ_ACK: begin
            bit_cnt <= '0;
            if (state == I2C_READ_ACK || is_read) begin
              state     <= I2C_READ;
              shreg     <= rd_byte;
              sda_oe    <= ~rd_byte[7];
              acc.rd    <= 1'b1;
              acc.addr  <= ptr;
              ptr       <= ptr + 8'h01;
            end else begin
              state  <= I2C_WRITE;
              sda_oe <= 1'b0;
            end
          end
          I2C_WRITE: begin
            if (bit_cnt == I2C_BITS) begin
              state  <= I2C_WRITE_ACK;
              sda_oe <= 1'b1;
              if (ptr_loaded) begin
                acc.wr   <= 1'b1;
                acc.addr <= ptr;
                acc.data <= shreg;
                ptr      <= ptr + 8'h01;
              end else begin
                ptr        <= shreg;
                ptr_loaded <= 1'b1;
              end
            end
          end
          I2C_WRITE_ACK: begin
            state   <= I2C_WRITE;
            sda_oe  <= 1'b0;
            bit_cnt <= '0;
          end
          I2C_READ: begin
            if (bit_cnt == I2C_BITS) begin
              state  <= I2C_READ_ACK;
              sda_oe <= 1'b0;
            end else begin
              sda_oe <= ~shreg[7];
            end
          end
          default: state <= I2C_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // global soft reset
  assign soft_rst = rst | port_general_control[GEN_GLOBAL];
  assign whole_chip_soft_reset = port_general_control[GEN_GLOBAL];
  // start flag exempt: the alert bank applies this policy to every
  // flag except its received_packet_start_flag
  assign read_clear_policy = port_general_control[GEN_POLICY];

  always_ff @(posedge sys_clk) begin
    if (soft_rst) begin
      vbus_low_alarm_upper <= RST_ZERO;
    end else if (wr_hit(acc, ADDR_ALARM_LOW_UPPER)) begin
      vbus_low_alarm_upper <= acc.data & THR_UPPER_MASK;
    end
  end
  assign vbus_low_alarm_level = {vbus_low_alarm_upper[1:0], vbus_low_alarm_lower};

  always_ff @(posedge sys_clk) begin
    if (soft_rst) begin
      vbus_undervoltage_flag <= 1'b0;
    end else begin
      vbus_undervoltage_flag <= ~voltage_alarm_inhibit &
                                (vbus_level < vbus_low_alarm_level);
    end
  end

  always_comb begin
    ev_set = RST_ZERO;
    ev_set[FLAG_TIMER_BIT] = slow_timer_expire;
    ev_set[FLAG_CC_BIT] = pins[2] & ~port_attached;
    ev_set[FLAG_OT_BIT] = pins[3];
    ev_clr = RST_ZERO;
    if (wr_hit(acc, ADDR_EVENT_FLAGS) && !read_clear_policy) begin
      ev_clr = acc.data & FLAG_MASK;
    end else if (acc.rd && acc.addr == ADDR_EVENT_FLAGS && read_clear_policy) begin
      ev_clr = FLAG_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (soft_rst) begin
      vendor_event_flags <= RST_ZERO;
    end else begin
      vendor_event_flags <= ((vendor_event_flags & ~ev_clr) | ev_set) & FLAG_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (soft_rst) begin
      vendor_event_enables <= RST_ZERO;
    end else if (wr_hit(acc, ADDR_EVENT_EN)) begin
      vendor_event_enables <= acc.data & EN_WMASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (soft_rst) begin
      vendor_irq <= 1'b0;
    end else begin
      vendor_irq <= |(vendor_event_flags & vendor_event_enables);
    end
  end

  assign pd_done = port_general_control[GEN_PD_RST] && pd_cnt == 5'(PD_RESET_CYCLES - 1);
  assign pd_engine_soft_reset = port_general_control[GEN_PD_RST];
  always_comb begin
    next_gen = port_general_control & ~(pd_done ? GEN_PD_MASK : RST_ZERO);
    if (wr_hit(acc, ADDR_GEN_CTRL)) begin
      next_gen = acc.data | (next_gen & GEN_PD_MASK);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (soft_rst) begin
      port_general_control <= RST_GEN_CTRL;
      pd_cnt               <= '0;
    end else begin
      port_general_control <= next_gen;
      pd_cnt <= (port_general_control[GEN_PD_RST] && !pd_done) ? pd_cnt + 5'h01 : '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (soft_rst) begin
      biphase_transmit_control <= RST_ZERO;
    end else if (wr_hit(acc, ADDR_TX_CTRL)) begin
      biphase_transmit_control <= (acc.data & TX_WMASK) |
                                  (acc.data | biphase_transmit_control) & ~TX_WMASK &
                                  8'(1 << TX_FRS);
    end else if (fast_swap_sent) begin
      biphase_transmit_control[TX_FRS] <= 1'b0;
    end
  end
  assign fast_swap_tx = biphase_transmit_control[TX_FRS];

  // ---------------------------------------------------------------
  // CC sampling and role toggle
  // ---------------------------------------------------------------
  interval_timer #(.W(16)) u_ms (
    .sys_clk (sys_clk),
    .rst     (soft_rst),
    .adv     (1'b1),
    .period  (16'(TICK_CYC)),
    .count   (),
    .done    (ms_tick)
  );

  interval_timer #(.W(5)) u_sample (
    .sys_clk (sys_clk),
    .rst     (soft_rst),
    .adv     (ms_tick),
    .period  (sample_ms(port_general_control[GEN_RATE_LSB +: 2])),
    .count   (),
    .done    (sample_due)
  );

  assign toggling   = auto_toggle_enable & ~port_attached;
  assign toggle_due = toggling & ms_tick &
                      (drp_cnt == dfp_ms(port_general_control[1:0]) - 8'h01 ||
                       drp_cnt == 8'(DRP_MS - 1));

  always_ff @(posedge sys_clk) begin
    if (soft_rst || !toggling) begin
      drp_cnt <= '0;
    end else if (ms_tick) begin
      drp_cnt <= (drp_cnt == 8'(DRP_MS - 1)) ? 8'h00 : drp_cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (soft_rst) begin
      advertise_dfp    <= 1'b0;
      cc_sample_strobe <= 1'b0;
    end else begin
      advertise_dfp <= toggling && drp_cnt < dfp_ms(port_general_control[1:0]);
      cc_sample_strobe <= (toggling && port_general_control[GEN_SAMPLE_CTL]) ?
                          toggle_due : sample_due;
    end
  end

  // ---------------------------------------------------------------
  // BIST carrier mode 2
  // ---------------------------------------------------------------
  // timed or continuous carrier
  always_ff @(posedge sys_clk) begin
    if (soft_rst) begin
      bist_carrier_on <= 1'b0;
      bist_cnt        <= '0;
    end else if (bist_mode2_start) begin
      bist_carrier_on <= 1'b1;
      bist_cnt        <= '0;
    end else if (bist_carrier_on && !biphase_transmit_control[TX_BIST_CONT]) begin
      if (bist_cnt == BW'(BIST_CONT_CYCLES - 1)) begin
        bist_carrier_on <= 1'b0;
      end else begin
        bist_cnt <= bist_cnt + BW'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_upper_write;
    wr_hit(acc, ADDR_ALARM_LOW_UPPER) && !soft_rst |=>
      vbus_low_alarm_upper == ($past(acc.data) & THR_UPPER_MASK);
  endproperty
  a_upper_write: assert property (p_upper_write) else $error("upper level lost");

  property p_undervolt;
    !soft_rst && !voltage_alarm_inhibit && vbus_level < vbus_low_alarm_level
      ##1 !soft_rst |-> vbus_undervoltage_flag;
  endproperty
  a_undervolt: assert property (p_undervolt) else $error("undervoltage missed");

  property p_timer_flag;
    slow_timer_expire && !soft_rst |=> vendor_event_flags[FLAG_TIMER_BIT];
  endproperty
  a_timer_flag: assert property (p_timer_flag) else $error("timer flag missed");

  property p_cc_flag;
    pins[2] && !port_attached && !soft_rst |=> vendor_event_flags[FLAG_CC_BIT];
  endproperty
  a_cc_flag: assert property (p_cc_flag) else $error("cc flag missed");

  property p_ot_flag;
    pins[3] && !soft_rst |=> vendor_event_flags[FLAG_OT_BIT];
  endproperty
  a_ot_flag: assert property (p_ot_flag) else $error("overtemp flag missed");

  property p_w1c;
    wr_hit(acc, ADDR_EVENT_FLAGS) && !read_clear_policy && acc.data[FLAG_OT_BIT]
      && !pins[3] && !soft_rst |=> !vendor_event_flags[FLAG_OT_BIT];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one clear failed");

  property p_irq;
    |(vendor_event_flags & vendor_event_enables) && !soft_rst |=> vendor_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");

  property p_pd_clear;
    $rose(pd_engine_soft_reset) |-> pd_engine_soft_reset[*8] ##[1:17] !pd_engine_soft_reset;
  endproperty
  a_pd_clear: assert property (p_pd_clear) else $error("pd reset length wrong");

  property p_global;
    whole_chip_soft_reset |=> port_general_control == RST_GEN_CTRL
      && vendor_event_enables == RST_ZERO;
  endproperty
  a_global: assert property (p_global) else $error("global reset incomplete");

  property p_frs_clear;
    fast_swap_tx && fast_swap_sent && !acc.wr && !soft_rst |=> !fast_swap_tx;
  endproperty
  a_frs_clear: assert property (p_frs_clear) else $error("swap bit not cleared");
endmodule
`default_nettype wire

// >>> bench/i2c_host.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_host #(
  parameter logic [6:0] ADDR = 7'h20
) (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // ------------------------------------------------
  // bit level: phases of 125 ns keep scl high/low 10 clocks
  // ------------------------------------------------
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #125 scl = 1'b1;
    #125 r = sda;
    #125 scl = 1'b0;
    #125;
  endtask
  task automatic start();
    sda_low = 1'b0;
    #125 scl = 1'b1;
    #125 sda_low = 1'b1;
    #125 scl = 1'b0;
    #125;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #125 scl = 1'b1;
    #125 sda_low = 1'b0;
    #125;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic n);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, n);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic [2:0] n;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q, n[0]);
    xfer(a, 1'b1, q, n[1]);
    xfer(d, 1'b1, q, n[2]);
    stop();
    nak = |n;
  endtask
  // read ends with a host nack, as the bus requires
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic [2:0] n;
    logic       x;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q, n[0]);
    xfer(a, 1'b1, q, n[1]);
    start();
    xfer({ADDR, 1'b1}, 1'b1, q, n[2]);
    xfer(8'hFF, 1'b1, d, x);
    stop();
    nak = |n;
  endtask
endmodule
`default_nettype wire

// >>> bench/typec_port_vendor_ctrl_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module typec_port_vendor_ctrl_regs_tb;
  import typec_vendor_pkg::*;
  localparam int TK = 20;
  localparam int DRP = 10;
  localparam int BC = 50;
  logic sys_clk = 0, rst = 1, tmr = 0, ccl = 0, att = 0, hot = 0, inh = 0, frs = 0;
  logic tog = 0, bst = 0;
  logic [9:0] vb = 0;
  logic [7:0] lo = 0, d, q;
  logic nk, h_low, scl, oe, uv, irq, stb, fst, pol, pdr, gsr, dfp, bc;
  wire logic sda = !(oe | h_low);
  int fail_count = 0, compares = 0, seed = 38990, n, k, m;
  always #12.5 sys_clk = ~sys_clk;
  i2c_host host (.scl(scl), .sda_low(h_low), .sda(sda));
  typec_port_vendor_ctrl_regs #(.TICK_CYC(TK), .BIST_CONT_CYCLES(BC), .DRP_MS(DRP)) DUT (
    .sys_clk(sys_clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(), .sda_oe(oe),
    .vbus_level(vb), .vbus_low_alarm_lower(lo), .voltage_alarm_inhibit(inh),
    .slow_timer_expire(tmr), .cc_over_limit(ccl), .port_attached(att),
    .thermal_shutdown_detector(hot), .auto_toggle_enable(tog), .bist_mode2_start(bst),
    .fast_swap_sent(frs), .vbus_undervoltage_flag(uv), .vendor_irq(irq),
    .read_clear_policy(pol), .pd_engine_soft_reset(pdr), .whole_chip_soft_reset(gsr),
    .cc_sample_strobe(stb), .advertise_dfp(dfp), .bist_carrier_on(bc), .fast_swap_tx(fst));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host.wr(a, v, nk);
    chk({7'h0, nk}, 8'h00);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, q, nk);
    chk(q, e);
  endtask
  task automatic test_done();
    if (fail_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #2ms;
    fail_count++;
    test_done();
  end
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    tick(3);
    rst = 0;
    tick(6);
    rd(ADDR_EVENT_FLAGS, RST_ZERO);
    rd(ADDR_EVENT_EN, RST_ZERO);
    rd(ADDR_GEN_CTRL, RST_GEN_CTRL);
    rd(ADDR_TX_CTRL, RST_ZERO);
    rd(8'h91, RST_ZERO);
    for (n = 0; n < 3; n++) begin
      d = 8'($random(seed)) & 8'hFD;
      wr(ADDR_EVENT_EN, d);
      rd(ADDR_EVENT_EN, d & EN_WMASK);
      wr(ADDR_ALARM_LOW_UPPER, d);
      rd(ADDR_ALARM_LOW_UPPER, d & THR_UPPER_MASK);
    end
    for (n = 0; n < 8; n++) begin
      vb = 10'($random(seed));
      lo = 8'($random(seed));
      inh = &n[1:0];
      tick(3);
      chk({7'h0, uv}, {7'h0, !inh && vb < {d[1:0], lo}});
    end
    wr(ADDR_EVENT_EN, FLAG_MASK);
    tmr = 1;
    tick(1);
    tmr = 0;
    tick(3);
    chk({7'h0, irq}, 8'h01);
    rd(ADDR_EVENT_FLAGS, 8'h10);
    wr(ADDR_EVENT_FLAGS, 8'h10);
    rd(ADDR_EVENT_FLAGS, RST_ZERO);
    chk({7'h0, irq}, 8'h00);
    ccl = 1;
    att = 1;
    tick(10);
    rd(ADDR_EVENT_FLAGS, RST_ZERO);
    att = 0;
    hot = 1;
    tick(10);
    ccl = 0;
    hot = 0;
    tick(10);
    rd(ADDR_EVENT_FLAGS, 8'h0C);
    wr(ADDR_EVENT_EN, 8'h00);
    tick(3);
    chk({7'h0, irq}, 8'h00);
    wr(ADDR_EVENT_FLAGS, 8'h0C);
    rd(ADDR_EVENT_FLAGS, RST_ZERO);
    wr(ADDR_GEN_CTRL, 8'h84);
    chk({7'h0, pol}, 8'h01);
    tmr = 1;
    tick(1);
    tmr = 0;
    rd(ADDR_EVENT_FLAGS, 8'h10);
    rd(ADDR_EVENT_FLAGS, RST_ZERO);
    // spacing between strobes at the default rate of two ticks
    n = 0;
    while (stb !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    n = 0;
    tick(1);
    while (stb !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    chk(8'(n + 1), 8'(2 * TK));
    wr(ADDR_TX_CTRL, 8'h06);
    chk({7'h0, fst}, 8'h01);
    frs = 1;
    tick(1);
    frs = 0;
    tick(2);
    chk({7'h0, fst}, 8'h00);
    rd(ADDR_TX_CTRL, 8'h04);
    // continuous carrier, then a timed one of BC cycles
    bst = 1;
    tick(1);
    bst = 0;
    tick(2 * BC);
    chk({7'h0, bc}, 8'h01);
    wr(ADDR_TX_CTRL, 8'h00);
    tick(BC);
    chk({7'h0, bc}, 8'h00);
    bst = 1;
    tick(1);
    bst = 0;
    tick(BC - 1);
    chk({7'h0, bc}, 8'h01);
    tick(1);
    chk({7'h0, bc}, 8'h00);
    fork
      wr(ADDR_GEN_CTRL, 8'h44);
      begin
        @(posedge pdr);
        #1;
        k = 0;
        while (pdr === 1'b1 && k < 100) begin
          tick(1);
          k++;
        end
        chk(8'(k), 8'(PD_RESET_CYCLES));
      end
    join
    chk({7'h0, pol}, 8'h00);
    rd(ADDR_GEN_CTRL, 8'h04);
    // role toggling: one full period to settle, then count over one period
    wr(ADDR_GEN_CTRL, 8'h14);
    tog = 1;
    tick(DRP * TK);
    k = 0;
    m = 0;
    repeat (DRP * TK) begin
      tick(1);
      k += dfp;
      m += stb;
    end
    chk(8'(k), 8'(DRP * DUTY_PCT_00 / PCT_FULL * TK));
    chk(8'(m), 8'h02);
    tog = 0;
    wr(ADDR_EVENT_EN, FLAG_MASK);
    wr(ADDR_GEN_CTRL, 8'h20);
    chk({7'h0, gsr}, 8'h00);
    rd(ADDR_GEN_CTRL, RST_GEN_CTRL);
    rd(ADDR_EVENT_EN, RST_ZERO);
    wr(ADDR_EVENT_EN, FLAG_MASK);
    rd(ADDR_EVENT_EN, FLAG_MASK);
    test_done();
  end
endmodule
`default_nettype wire
